// File: analyzer_trigger_link.sv
`timescale 1ns/1ps
`include "trigger_link_cfg.svh"

// Overview of operation
// [R1] state match output pulls low while state analyzer samples a matching word
// [R2] timing match output pulls low while timing analyzer samples a matching word
// [R3] external qualifier is active high; low level blocks qualification
// [R4] any link-select bit set in restart or trigger levels makes a slave
// [R5] no link-select bit set makes a master driving the cascade line
// [R6] master pulls cascade line low once triggering fully satisfied
// [R7] role comes only from select bits, cable presence ignored
// [R8] master collect: load parameters, release line, enable collection
// [R9] slave collect: load, release, wait line high, then enable collection
// [R10] cascade line is open collector, low while any unit holds it
// [R11] software starts every slave before the master
// [R12] line watched only when select bit active; clearing bits gives master
// [R13] exactly one master exists among linked analyzers
// [R14] qualify bit adds external input; link bit involves cascade line
// [R15] releasing means stop pulling low; level rises after all release
module analyzer_trigger_link
(
	input  wire logic                       clock,
	input  wire logic                       resetn,
	input  wire logic [`ADDR_WIDTH-1:0]     address,
	input  wire logic [7:0]                 write_data,
	input  wire logic                       write_strobe,
	input  wire logic                       read_strobe,
	output logic      [7:0]                 read_data,
	input  wire logic                       state_word_match,
	input  wire logic                       timing_word_match,
	input  wire logic                       state_trigger_done,
	input  wire logic                       restart_link_bit,
	input  wire logic                       level_link_bits,
	input  wire logic                       external_qualifier_in,
	output logic                            qualified_out,
	output logic                            state_match_out_n,
	output logic                            timing_match_out,
	output logic                            collect_enable,
	input  wire logic                       cascade_in,
	output logic                            cascade_out,
	output logic                            cascade_oe_n
);
	import link_pkg::*;

	logic [`CTRL_WIDTH-1:0] control_r;
	collect_state_type      state_r;
	logic [3:0]             load_count_r;
	logic                   slave_r;
	logic                   hold_low_r;

	////////////////////////////////////////////////////////////////////
	// decoding

	// one decoder for every write strobe keeps the index compares from drifting apart
	function automatic logic strobe_hit(
		input logic                   strobe,
		input logic [`ADDR_WIDTH-1:0] index,
		input logic [`ADDR_WIDTH-1:0] target
	);
		return strobe && (index == target);
	endfunction : strobe_hit

	////////////////////////////////////////////////////////////////////
	// role

	link_role_select role_select (
		.clock            (clock),
		.resetn           (resetn),
		.restart_link_bit (restart_link_bit),
		.level_link_bits  (level_link_bits),
		.slave_r          (slave_r)
	);

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock) begin
		if (!resetn) begin
			control_r <= `CTRL_RESET;
		end else if (strobe_hit(write_strobe, address, `ADDR_CONTROL)) begin
			control_r <= write_data[`CTRL_WIDTH-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			read_data <= 8'h00;
		end else if (read_strobe) begin
			unique case (address)
				`ADDR_CONTROL: read_data <= {4'h0, control_r};
				`ADDR_STATUS:  read_data <= {4'h0, slave_r, 3'(state_r)};
				default:       read_data <= 8'h00;
			endcase
		end else begin
			read_data <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// match outputs: registered, so one clock behind the recognizer

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_match_out_n <= 1'b1;
			timing_match_out  <= 1'b1;
		end else begin
			state_match_out_n <= ~(control_r[`CTRL_STATE_RUN_BIT] & state_word_match); // [R1]
			timing_match_out  <= ~(control_r[`CTRL_TIMING_RUN_BIT] & timing_word_match); // [R2]
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			qualified_out <= 1'b1;
		end else begin
			// qualify bit clear leaves the input out entirely [R14]
			qualified_out <= ~control_r[`CTRL_EXT_QUAL_BIT] | external_qualifier_in; // [R3]
		end
	end

	////////////////////////////////////////////////////////////////////
	// collect sequence

	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_r      <= ST_IDLE;
			load_count_r <= 4'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (strobe_hit(write_strobe, address, `ADDR_COLLECT)) begin
						state_r      <= ST_LOAD; // [R8] [R9]
						load_count_r <= `LOAD_CYCLES;
					end
				end
				ST_LOAD: begin
					if (load_count_r == 4'h1) begin
						state_r <= ST_RELEASE;
					end
					load_count_r <= load_count_r - 4'h1;
				end
				ST_RELEASE: begin
					// slave waits only if the line is involved [R12] [R14]
					state_r <= (slave_r && control_r[`CTRL_LINK_SEL_BIT]) ?
						ST_WAIT_LINK : ST_COLLECT; // [R8]
				end
				ST_WAIT_LINK: begin
					// relies on slaves being started before the master [R11]
					if (cascade_in) begin
						state_r <= ST_COLLECT; // [R9] [R15]
					end
				end
				ST_COLLECT: begin
					if (!slave_r && state_trigger_done) begin
						state_r <= ST_TRIGGERED;
					end
				end
				ST_TRIGGERED: begin
					if (strobe_hit(write_strobe, address, `ADDR_COLLECT)) begin
						state_r      <= ST_LOAD;
						load_count_r <= `LOAD_CYCLES;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			collect_enable <= 1'b0;
		end else begin
			collect_enable <= (state_r == ST_COLLECT);
		end
	end

	////////////////////////////////////////////////////////////////////
	// cascade line, open collector: out fixed low, enable only

	always_ff @(posedge clock) begin
		if (!resetn) begin
			hold_low_r <= 1'b1;
		end else if (state_r == ST_IDLE ||
				(state_r == ST_LOAD && load_count_r != 4'h1)) begin
			// line held until parameters are loaded; letting go on the last load
			// cycle shows the release a clock before collection opens [R8]
			hold_low_r <= 1'b1;
		end else if (state_r == ST_TRIGGERED && !slave_r) begin
			hold_low_r <= 1'b1; // [R6]
		end else begin
			hold_low_r <= 1'b0; // [R15]
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			cascade_out  <= 1'b0;
			cascade_oe_n <= 1'b0;
		end else begin
			cascade_out  <= 1'b0; // [R10]
			cascade_oe_n <= ~hold_low_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	master_fire_a: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		(state_r == ST_TRIGGERED && !slave_r) |=> ##1 !cascade_oe_n)
		else $error("master not pulling cascade low after trigger");

	slave_wait_a: assert property (@(posedge clock) disable iff (!resetn) // [R9]
		(state_r == ST_WAIT_LINK && !cascade_in) |=> state_r == ST_WAIT_LINK)
		else $error("slave left wait while line low");

	order_load_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r == ST_LOAD) |=> (state_r != ST_COLLECT))
		else $error("collection enabled before release");

	state_match_a: assert property (@(posedge clock) disable iff (!resetn) // [R1]
		(control_r[`CTRL_STATE_RUN_BIT] && state_word_match) |=> !state_match_out_n)
		else $error("state match output not low");

	timing_match_a: assert property (@(posedge clock) disable iff (!resetn) // [R2]
		(control_r[`CTRL_TIMING_RUN_BIT] && timing_word_match) |=> !timing_match_out)
		else $error("timing match output not low");

	ext_qual_a: assert property (@(posedge clock) disable iff (!resetn) // [R3]
		(control_r[`CTRL_EXT_QUAL_BIT] && !external_qualifier_in) |=> !qualified_out)
		else $error("low qualifier did not inhibit");

	open_drain_a: assert property (@(posedge clock) disable iff (!resetn) // [R10]
		!cascade_out)
		else $error("cascade driven high");

	master_skip_a: assert property (@(posedge clock) disable iff (!resetn) // [R5]
		(state_r == ST_RELEASE && !slave_r) |=> state_r == ST_COLLECT)
		else $error("master waited on cascade line");

	collect_out_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r == ST_COLLECT) |=> collect_enable)
		else $error("collect enable missing");

	////////////////////////////////////////////////////////////////////
	// checks: match outputs and qualifier

	state_quiet_a: assert property (@(posedge clock) disable iff (!resetn) // [R1]
		(!control_r[`CTRL_STATE_RUN_BIT]) |=> state_match_out_n)
		else $error("state match output low while not sampling");

	timing_quiet_a: assert property (@(posedge clock) disable iff (!resetn) // [R2]
		(!control_r[`CTRL_TIMING_RUN_BIT]) |=> timing_match_out)
		else $error("timing match output low while not sampling");

	qual_pass_a: assert property (@(posedge clock) disable iff (!resetn) // [R3] [R14]
		(!control_r[`CTRL_EXT_QUAL_BIT] || external_qualifier_in) |=> qualified_out)
		else $error("qualifier blocked without cause");

	////////////////////////////////////////////////////////////////////
	// checks: role

	slave_role_a: assert property (@(posedge clock) disable iff (!resetn) // [R4]
		(restart_link_bit || level_link_bits) |=> slave_r)
		else $error("link-select bit did not give slave role");

	master_role_a: assert property (@(posedge clock) disable iff (!resetn) // [R5] [R12]
		(!restart_link_bit && !level_link_bits) |=> !slave_r)
		else $error("no link-select bit but still slave");

	////////////////////////////////////////////////////////////////////
	// checks: collect sequence

	idle_stay_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r == ST_IDLE && !strobe_hit(write_strobe, address, `ADDR_COLLECT)) |=>
		(state_r == ST_IDLE))
		else $error("left idle without a collect write");

	load_length_a: assert property (@(posedge clock) disable iff (!resetn) // [R8] [R9]
		(state_r == ST_IDLE && strobe_hit(write_strobe, address, `ADDR_COLLECT)) |=>
		(state_r == ST_LOAD) [*4] ##1 (state_r == ST_RELEASE))
		else $error("parameter load not four cycles");

	restart_load_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r == ST_TRIGGERED && strobe_hit(write_strobe, address, `ADDR_COLLECT)) |=>
		(state_r == ST_LOAD && load_count_r == `LOAD_CYCLES))
		else $error("new collect did not reload parameters");

	load_count_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r == ST_LOAD) |-> (load_count_r != 4'h0 && load_count_r <= `LOAD_CYCLES))
		else $error("load counter out of range");

	release_step_a: assert property (@(posedge clock) disable iff (!resetn) // [R8] [R15]
		(state_r == ST_LOAD && load_count_r == 4'h1) |=>
		(state_r == ST_RELEASE && !hold_low_r))
		else $error("line not released after load");

	wait_enter_a: assert property (@(posedge clock) disable iff (!resetn) // [R9] [R12]
		(state_r == ST_RELEASE && slave_r && control_r[`CTRL_LINK_SEL_BIT]) |=>
		(state_r == ST_WAIT_LINK))
		else $error("linked slave did not wait");

	wait_leave_a: assert property (@(posedge clock) disable iff (!resetn) // [R9] [R15]
		(state_r == ST_WAIT_LINK && cascade_in) |=> (state_r == ST_COLLECT))
		else $error("slave stuck after line rose");

	wait_closed_a: assert property (@(posedge clock) disable iff (!resetn) // [R9]
		(state_r == ST_WAIT_LINK) |=> !collect_enable)
		else $error("collection open while waiting on line");

	trigger_step_a: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		(state_r == ST_COLLECT && !slave_r && state_trigger_done) |=>
		(state_r == ST_TRIGGERED))
		else $error("master missed full trigger");

	slave_no_fire_a: assert property (@(posedge clock) disable iff (!resetn) // [R4]
		(state_r == ST_COLLECT && slave_r) |=> (state_r == ST_COLLECT))
		else $error("slave left collection");

	trigger_stay_a: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		(state_r == ST_TRIGGERED && !strobe_hit(write_strobe, address, `ADDR_COLLECT)) |=>
		(state_r == ST_TRIGGERED))
		else $error("left triggered without a collect write");

	collect_stop_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		(state_r != ST_COLLECT) |=> !collect_enable)
		else $error("collect enable outside collection");

	release_first_a: assert property (@(posedge clock) disable iff (!resetn) // [R8]
		$rose(collect_enable) |-> $past(cascade_oe_n))
		else $error("collection opened before line release");

	////////////////////////////////////////////////////////////////////
	// checks: cascade line

	load_hold_a: assert property (@(posedge clock) disable iff (!resetn) // [R8] [R15]
		(state_r == ST_LOAD && load_count_r != 4'h1) |=> hold_low_r)
		else $error("line let go during load");

	wait_release_a: assert property (@(posedge clock) disable iff (!resetn) // [R9] [R15]
		(state_r == ST_WAIT_LINK) |-> !hold_low_r)
		else $error("waiting slave still holds line");

	idle_pull_a: assert property (@(posedge clock) disable iff (!resetn) // [R15]
		(state_r == ST_IDLE) |=> ##1 !cascade_oe_n)
		else $error("idle unit not holding line");

	collect_free_a: assert property (@(posedge clock) disable iff (!resetn) // [R5] [R15]
		(state_r == ST_COLLECT) |=> ##1 cascade_oe_n)
		else $error("line held during collection");

	slave_quiet_a: assert property (@(posedge clock) disable iff (!resetn) // [R4] [R6]
		(state_r == ST_TRIGGERED && slave_r) |=> !hold_low_r)
		else $error("slave pulling line after trigger");

endmodule : analyzer_trigger_link

// File: far_analyzer.sv
`timescale 1ns/1ps

// the other analyzer on the shared cascade line, held up by a pull-up
module far_analyzer (
	input  wire logic hold,
	input  wire logic dut_oe_n,
	input  wire logic dut_out,
	output logic      line
);
	////////////////////////////////////////////////////////////////////////////
	// hold stands for the single master, kept low until started last
	// wired-and: the line rises only once every party lets go
	// a driven-high out while enabled would lift the line and show up here
	assign line = ~hold & (dut_oe_n | dut_out);
endmodule : far_analyzer

// File: link_pkg.sv
package link_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_RELEASE,
		ST_WAIT_LINK,
		ST_COLLECT,
		ST_TRIGGERED
	} collect_state_type;
endpackage : link_pkg

// File: link_role_select.sv
`timescale 1ns/1ps
`include "trigger_link_cfg.svh"

// decides master or slave purely from link-select bits
module link_role_select (
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic                 restart_link_bit,
	input  wire logic                 level_link_bits,
	output logic                      slave_r
);
	always_ff @(posedge clock) begin
		if (!resetn) begin
			slave_r <= 1'b0;
		end else begin
			// cable presence plays no part [R7] [R4] [R5] [R12]
			slave_r <= restart_link_bit | level_link_bits;
		end
	end
endmodule : link_role_select

// File: tb.sv
`timescale 1ns/1ps
`include "trigger_link_cfg.svh"

module tb;
	logic       clock = 1'b0;
	logic       resetn;
	logic [3:0] address;
	logic [7:0] write_data;
	logic       write_strobe;
	logic       read_strobe;
	logic [7:0] read_data;
	logic       state_word_match;
	logic       timing_word_match;
	logic       state_trigger_done;
	logic       restart_link_bit;
	logic       level_link_bits;
	logic       external_qualifier_in;
	logic       qualified_out;
	logic       state_match_out_n;
	logic       timing_match_out;
	logic       collect_enable;
	logic       cascade_oe_n;
	logic       cascade_out;
	logic       line;
	logic       hold;
	logic [7:0] v;
	int         fails;
	int         cmp_count;

	analyzer_trigger_link analyzer_trigger_link_inst (.clock(clock), .resetn(resetn),
		.address(address), .write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data),
		.state_word_match(state_word_match), .timing_word_match(timing_word_match),
		.state_trigger_done(state_trigger_done), .restart_link_bit(restart_link_bit),
		.level_link_bits(level_link_bits), .external_qualifier_in(external_qualifier_in),
		.qualified_out(qualified_out), .state_match_out_n(state_match_out_n),
		.timing_match_out(timing_match_out), .collect_enable(collect_enable),
		.cascade_in(line), .cascade_out(cascade_out), .cascade_oe_n(cascade_oe_n));
	far_analyzer far_analyzer_inst (.hold(hold), .dut_oe_n(cascade_oe_n),
		.dut_out(cascade_out), .line(line));

	always #50 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1;
		v = read_data;
	endtask : rd

	task automatic pause(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : pause

	// bounded wait; a lost start would otherwise hang the run
	task automatic wait_collect();
		int n;
		n = 0;
		while (collect_enable !== 1'b1) begin
			pause(1);
			n++;
			if (n > 40) begin
				fails++;
				finish_test();
			end
		end
	endtask : wait_collect

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, address, write_data, write_strobe, read_strobe} = '0;
		{state_word_match, timing_word_match, state_trigger_done, hold} = '0;
		{restart_link_bit, level_link_bits, external_qualifier_in} = '0;
		fails = 0;
		cmp_count = 0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		rd(`ADDR_CONTROL);
		chk(v, {4'h0, `CTRL_RESET});
		rd(4'h7);
		chk(v, 8'h00);
		wr(`ADDR_CONTROL, 8'h03);
		state_word_match <= 1'b1;
		timing_word_match <= 1'b1;
		pause(2);
		chk({state_match_out_n, timing_match_out}, 8'h00);
		wr(`ADDR_CONTROL, 8'h04);
		pause(2);
		chk({state_match_out_n, timing_match_out, qualified_out}, 8'h06);
		@(posedge clock);
		external_qualifier_in <= 1'b1;
		pause(2);
		chk(qualified_out, 8'h01);
		// master start: line released before collection opens
		wr(`ADDR_COLLECT, 8'h01);
		wait_collect();
		chk({cascade_oe_n, collect_enable}, 8'h03);
		@(posedge clock);
		state_trigger_done <= 1'b1;
		pause(4);
		chk({cascade_oe_n, cascade_out}, 8'h00);
		@(posedge clock);
		state_trigger_done <= 1'b0;
		restart_link_bit <= 1'b1;
		hold <= 1'b1;
		wr(`ADDR_CONTROL, 8'h08);
		rd(`ADDR_STATUS);
		chk(v[3], 8'h01);
		wr(`ADDR_COLLECT, 8'h01);
		pause(20);
		chk({cascade_oe_n, collect_enable, line}, 8'h04);
		@(posedge clock);
		hold <= 1'b0;
		wait_collect();
		chk(line, 8'h01);
		@(posedge clock);
		restart_link_bit <= 1'b0;
		level_link_bits <= 1'b1;
		rd(`ADDR_STATUS);
		chk(v[3], 8'h01);
		@(posedge clock);
		level_link_bits <= 1'b0;
		wr(`ADDR_CONTROL, 8'h00);
		rd(`ADDR_STATUS);
		chk(v[3], 8'h00);
		// second reset mid-run, then a slave whose link bit is clear must not wait
		@(posedge clock);
		resetn <= 1'b0;
		restart_link_bit <= 1'b1;
		hold <= 1'b1;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		#1;
		chk({collect_enable, cascade_oe_n}, 8'h00);
		wr(`ADDR_COLLECT, 8'h01);
		wait_collect();
		chk({cascade_oe_n, collect_enable, line}, 8'h06);
		finish_test();
	end
endmodule : tb

// File: trigger_link_cfg.svh
`ifndef TRIGGER_LINK_CFG_SVH
`define TRIGGER_LINK_CFG_SVH

// register indices on the plain port
`define ADDR_CONTROL        4'h0
`define ADDR_STATUS         4'h1
`define ADDR_COLLECT        4'h2
`define ADDR_WIDTH          4

// control register fields
`define CTRL_STATE_RUN_BIT  0
`define CTRL_TIMING_RUN_BIT 1
`define CTRL_EXT_QUAL_BIT   2
`define CTRL_LINK_SEL_BIT   3
`define CTRL_WIDTH          4
`define CTRL_RESET          4'h0

// collect register: writing any value starts the collect sequence
`define COLLECT_GO_BIT      0

// status register fields
`define STAT_STATE_BIT      0
`define STAT_SLAVE_BIT      3
`define STAT_WIDTH          8

// parameter load time in cycles
`define LOAD_CYCLES         4'h4

`endif
